// >>> src/ebwi_top.sv
// External bus interface with wait-state generator and ready stretching
`default_nettype none
`include "ebwi_params.svh"
module ebwi_top
    import ebwi_pkg::*;
(
    input wire logic sys_clk, // CPU cycle clock
    input wire logic rst_n, // Synchronous reset
    input wire logic reset_n_pin, // Reset pin, asynchronous
    input wire logic req, // Core access request pulse
    input wire logic req_write, // 1 write, 0 read
    input wire ebwi_space_t req_space, // Target space
    input wire logic [`EBWI_AW-1:0] req_addr, // Address
    input wire logic [`EBWI_DW-1:0] req_wdata, // Write data
    input wire logic ready, // External ready pin
    input wire logic [`EBWI_DW-1:0] ext_data_in, // Data bus input
    output logic [`EBWI_AW-1:0] ext_addr_q, // Address bus
    output logic [`EBWI_DW-1:0] ext_data_out_q, // Data bus output
    output logic ext_data_oe_q, // Data bus drive enable
    output logic read_select_n_q, // Read select
    output logic write_enable_n_q, // Write enable
    output logic access_strobe_n_q, // Access strobe
    output logic read_not_write_q, // Direction, high on read
    output logic program_select_n_q, // Program space select
    output logic data_select_n_q, // Data space select
    output logic io_select_n_q, // I/O space select
    output logic busy_q, // Access in progress, core stalls
    output logic done_q, // One-cycle completion pulse
    output logic [`EBWI_DW-1:0] rdata_q, // Read data
    output logic [`EBWI_AW-1:0] restart_addr_q, // Fetch address after reset
    output logic [`EBWI_DW-1:0] wscr_q // Wait control register value
);
    ebwi_state_t state_q;
    logic rdy_s;
    logic rst_pin_s;
    logic srst_n;
    logic [`EBWI_WSW-1:0] count_sel;
    logic [`EBWI_WSW-1:0] wait_q;
    logic sel_pending_q;
    logic ctrl_wr;
    ebwi_sync u_rdy (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(ready),
        .level_q(rdy_s)
    );
    ebwi_sync u_rst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(reset_n_pin),
        .level_q(rst_pin_s)
    );
    assign srst_n = rst_n & rst_pin_s; // [R11]
    // ==================================================
    // Wait control register, written through I/O space
    // Writes to it stay on chip; the external bus is not driven
    assign ctrl_wr = req && req_write && req_space == EBWI_SP_IO && req_addr == `EBWI_WSCR_ADDR
        && state_q == EBWI_ST_IDLE; // [R10]
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            wscr_q <= `EBWI_WSCR_RST; // [R11]
        end else if (ctrl_wr) begin
            wscr_q <= req_wdata; // [R10]
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            restart_addr_q <= `EBWI_RESTART_ADDR; // [R11]
        end
    end
    ebwi_wait_sel u_sel (
        .sys_clk(sys_clk),
        .rst_n(srst_n),
        .wscr(wscr_q),
        .space(req_space),
        .addr(req_addr),
        .count_q(count_sel)
    );
    // ==================================================
    // Access sequencer
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            state_q <= EBWI_ST_IDLE;
            sel_pending_q <= 1'b0;
        end else begin
            case (state_q)
                EBWI_ST_IDLE: begin
                    if (req && !ctrl_wr) begin
                        state_q <= EBWI_ST_ACC;
                        sel_pending_q <= 1'b1;
                    end
                end
                EBWI_ST_ACC: begin
                    sel_pending_q <= 1'b0;
                    // Count and ready both must allow the end
                    if (!sel_pending_q && wait_q == '0 && rdy_s) begin
                        state_q <= EBWI_ST_DONE; // [R14] [R6]
                    end
                end
                EBWI_ST_DONE: state_q <= EBWI_ST_IDLE;
                default: state_q <= EBWI_ST_IDLE;
            endcase
        end
    end
    // One wait per cycle; ready is tested again every cycle while low
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            wait_q <= '0;
        end else if (state_q == EBWI_ST_ACC && sel_pending_q) begin
            wait_q <= count_sel; // [R8]
        end else if (state_q == EBWI_ST_ACC && wait_q != '0) begin
            wait_q <= wait_q - 1'b1; // [R9] [R5]
        end
    end
    // ==================================================
    // Bus pins
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            ext_addr_q <= '0;
            ext_data_out_q <= '0;
            read_not_write_q <= 1'b1;
            program_select_n_q <= 1'b1;
            data_select_n_q <= 1'b1;
            io_select_n_q <= 1'b1;
        end else if (state_q == EBWI_ST_IDLE && req && !ctrl_wr) begin
            ext_addr_q <= req_addr;
            ext_data_out_q <= req_wdata;
            read_not_write_q <= !req_write; // [R4]
            program_select_n_q <= req_space != EBWI_SP_PROG; // [R13]
            data_select_n_q <= req_space != EBWI_SP_DATA;
            io_select_n_q <= req_space != EBWI_SP_IO;
        end else if (state_q == EBWI_ST_DONE) begin
            read_not_write_q <= 1'b1;
            program_select_n_q <= 1'b1;
            data_select_n_q <= 1'b1;
            io_select_n_q <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            access_strobe_n_q <= 1'b1;
            read_select_n_q <= 1'b1;
            write_enable_n_q <= 1'b1;
            ext_data_oe_q <= 1'b0;
        end else if (state_q == EBWI_ST_IDLE && req && !ctrl_wr) begin
            access_strobe_n_q <= 1'b0; // [R3]
            read_select_n_q <= req_write; // [R1]
            write_enable_n_q <= !req_write; // [R2]
            ext_data_oe_q <= req_write;
        end else if (state_q == EBWI_ST_ACC && !sel_pending_q && wait_q == '0 && rdy_s) begin
            access_strobe_n_q <= 1'b1; // [R3]
            read_select_n_q <= 1'b1; // [R1]
            write_enable_n_q <= 1'b1; // [R2]
        end else if (state_q == EBWI_ST_DONE) begin
            ext_data_oe_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!srst_n) begin
            rdata_q <= '0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= state_q == EBWI_ST_ACC && !sel_pending_q && wait_q == '0 && rdy_s;
            busy_q <= (state_q == EBWI_ST_IDLE && req && !ctrl_wr) || state_q == EBWI_ST_ACC; // [R6]
            if (state_q == EBWI_ST_ACC && !sel_pending_q && wait_q == '0 && rdy_s && read_not_write_q) begin
                rdata_q <= ext_data_in;
            end
        end
    end
    // ==================================================
    // Checks
    AST_RD_LOW: assert property (@(posedge sys_clk) disable iff (!srst_n)
        !read_select_n_q |-> !access_strobe_n_q && read_not_write_q) // [R1]
        else $error("read select without strobe or read direction");
    AST_WE_LOW: assert property (@(posedge sys_clk) disable iff (!srst_n)
        !write_enable_n_q |-> !access_strobe_n_q && !read_not_write_q) // [R2]
        else $error("write enable without strobe or write direction");
    AST_ACCESS_STROBE_N_START: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_IDLE && req && !ctrl_wr |=> !access_strobe_n_q) // [R3]
        else $error("strobe not asserted at access start");
    AST_DIR: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_IDLE && req && !ctrl_wr |=> read_not_write_q == !$past(req_write)) // [R4]
        else $error("direction does not match request");
    AST_READY_HOLD: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_ACC && !rdy_s |=> state_q == EBWI_ST_ACC) // [R6]
        else $error("access ended while ready low");
    AST_WAIT_STEP: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_ACC && !sel_pending_q && wait_q != '0 |=> wait_q == $past(wait_q) - 1'b1) // [R9]
        else $error("wait count did not step by one");
    AST_END: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_ACC && !sel_pending_q && wait_q == '0 && rdy_s |=> done_q && access_strobe_n_q) // [R14]
        else $error("access did not end when allowed");
    AST_PS: assert property (@(posedge sys_clk) disable iff (!srst_n)
        !program_select_n_q |-> data_select_n_q && io_select_n_q) // [R13]
        else $error("program select overlaps another space");
    AST_RESET: assert property (@(posedge sys_clk)
        !srst_n |=> restart_addr_q == `EBWI_RESTART_ADDR && access_strobe_n_q) // [R11]
        else $error("reset state wrong");
    AST_RD_START: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_IDLE && req && !ctrl_wr && !req_write |=> !read_select_n_q) // [R1]
        else $error("read select not asserted at read start");
    AST_WE_START: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_IDLE && req && !ctrl_wr && req_write |=> !write_enable_n_q) // [R2]
        else $error("write enable not asserted at write start");
    AST_ACCESS_STROBE_N_HOLD: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_ACC |-> !access_strobe_n_q) // [R3]
        else $error("strobe released inside an access");
    AST_BUSY: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_ACC |-> busy_q) // [R6]
        else $error("busy low while access open");
    AST_DONE_ONE: assert property (@(posedge sys_clk) disable iff (!srst_n)
        done_q |=> !done_q) // [R14]
        else $error("completion pulse longer than one cycle");
    AST_CTRL_QUIET: assert property (@(posedge sys_clk) disable iff (!srst_n)
        ctrl_wr |=> access_strobe_n_q && busy_q == 1'b0) // [R10]
        else $error("control register write reached the external bus");
    AST_WAIT_LOAD: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_ACC && sel_pending_q |=> wait_q == $past(count_sel)) // [R8]
        else $error("wait count not loaded from selected field");
    AST_PS_START: assert property (@(posedge sys_clk) disable iff (!srst_n)
        state_q == EBWI_ST_IDLE && req && !ctrl_wr && req_space == EBWI_SP_PROG |=> !program_select_n_q) // [R13]
        else $error("program select not asserted for program access");
endmodule
`default_nettype wire

// >>> src/ebwi_params.svh
// Constants of the external bus wait interface
// ==========================================================================
// Behaviour
// R1: Read select low during external reads
// R2: Write enable low during external writes
// R3: Access strobe low for every external access
// R4: Direction output shows read or write
// R5: Ready low requests waits; resample each cycle
// R6: Access stalls until ready returns high
// R7: Upper program space uses its own field
// R8: Programmed wait count per space
// R9: Each wait state lasts one cycle
// R10: Wait control register sits in I/O space
// R11: Reset gives known state, restart at 0000h
// R12: Lower program space uses its own field
// R13: Program select low for program accesses
// R14: Access ends when count done and ready high
`ifndef EBWI_PARAMS_SVH
`define EBWI_PARAMS_SVH
`define EBWI_AW 16
`define EBWI_DW 16
`define EBWI_WSW 3
`define EBWI_WSCR_ADDR 16'hffff
`define EBWI_WSCR_RST 16'h0fff
`define EBWI_PLO_LSB 0
`define EBWI_PUP_LSB 3
`define EBWI_DAT_LSB 6
`define EBWI_IO_LSB 9
`define EBWI_RESTART_ADDR 16'h0000
`define EBWI_UPPER_BIT 15
`endif

// >>> src/ebwi_pkg.sv
// Types of the external bus wait interface
`default_nettype none
package ebwi_pkg;
    typedef enum logic [1:0] {
        EBWI_SP_PROG = 2'b00,
        EBWI_SP_DATA = 2'b01,
        EBWI_SP_IO = 2'b10
    } ebwi_space_t;
    typedef enum logic [1:0] {
        EBWI_ST_IDLE = 2'b00,
        EBWI_ST_ACC = 2'b01,
        EBWI_ST_DONE = 2'b10
    } ebwi_state_t;
endpackage
`default_nettype wire

// >>> src/ebwi_sync.sv
// Three-stage synchroniser for the ready and reset pins
`default_nettype none
module ebwi_sync (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic pin_in, // Asynchronous pin
    output logic level_q // Filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // Level changes only once two later stages agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_q <= 1'b1;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule
`default_nettype wire

// >>> src/ebwi_wait_sel.sv
// Selects the programmed wait count for an access
`default_nettype none
`include "ebwi_params.svh"
module ebwi_wait_sel
    import ebwi_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [`EBWI_DW-1:0] wscr, // Wait control register
    input wire ebwi_space_t space, // Space of request
    input wire logic [`EBWI_AW-1:0] addr, // Address of request
    output logic [`EBWI_WSW-1:0] count_q // Selected wait count
);
    function automatic logic [`EBWI_WSW-1:0] field(input logic [`EBWI_DW-1:0] r, input int lsb);
        field = r[lsb +: `EBWI_WSW];
    endfunction
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            case (space)
                EBWI_SP_PROG: begin
                    if (addr[`EBWI_UPPER_BIT]) begin
                        count_q <= field(wscr, `EBWI_PUP_LSB); // [R7]
                    end else begin
                        count_q <= field(wscr, `EBWI_PLO_LSB); // [R12]
                    end
                end
                EBWI_SP_DATA: count_q <= field(wscr, `EBWI_DAT_LSB); // [R8]
                EBWI_SP_IO: count_q <= field(wscr, `EBWI_IO_LSB); // [R8]
                default: count_q <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/ebwi_mem_model.sv
// External memory and ready source on the far side of the bus
`default_nettype none
module ebwi_mem_model (
    input wire logic sys_clk, // Clock
    input wire logic [15:0] addr, // Address bus
    input wire logic [15:0] wdata, // Write data
    input wire logic rd_n, // Read select
    input wire logic we_n, // Write enable
    input wire logic access_strobe_n_n, // Access strobe
    input wire logic [7:0] stall, // Wait cycles to request
    output logic [15:0] rdata, // Read data
    output logic ready // Low requests waits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [int];
    logic access_strobe_n_d = 1'b1;
    int left = 0;
    initial rdata = 16'h0000;
    initial ready = 1'b1;
    always @(posedge sys_clk) begin
        if (!we_n) begin
            mem[int'(addr)] = wdata;
        end
        // Unselected bus must not look valid, so it toggles
        if (!rd_n) begin
            rdata <= mem.exists(int'(addr)) ? mem[int'(addr)] : addr ^ 16'h5a5a;
        end else begin
            rdata <= ~rdata;
        end
        if (access_strobe_n_d && !access_strobe_n_n) begin
            left = stall;
        end else if (left > 0) begin
            left = left - 1;
        end
        access_strobe_n_d <= access_strobe_n_n;
        ready <= (left == 0);
    end
endmodule
`default_nettype wire

// >>> verif/test_ebwi_top.sv
// Self-checking bench for the external bus wait interface
`default_nettype none
module test_ebwi_top
    import ebwi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, reset_n_pin = 1, req = 0, req_write = 0, ready;
    ebwi_space_t req_space = EBWI_SP_PROG;
    logic [15:0] req_addr = 0, req_wdata = 0, ext_data_in, ext_addr_q, ext_data_out_q, rdata_q;
    logic [15:0] restart_addr_q, wscr_q, wscr_m;
    logic ext_data_oe_q, read_select_n_q, write_enable_n_q, access_strobe_n_q, read_not_write_q;
    logic program_select_n_q, data_select_n_q, io_select_n_q, busy_q, done_q;
    logic [7:0] stall = 0;
    logic [15:0] ref_mem [int];
    int n_fail = 0, samples_checked = 0, seed = 32'hf4d6;
    always #5 sys_clk = ~sys_clk;
    ebwi_top ebwi_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reset_n_pin(reset_n_pin), .req(req),
        .req_write(req_write), .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
        .ready(ready), .ext_data_in(ext_data_in), .ext_addr_q(ext_addr_q), .ext_data_out_q(ext_data_out_q),
        .ext_data_oe_q(ext_data_oe_q), .read_select_n_q(read_select_n_q), .write_enable_n_q(write_enable_n_q),
        .access_strobe_n_q(access_strobe_n_q), .read_not_write_q(read_not_write_q),
        .program_select_n_q(program_select_n_q), .data_select_n_q(data_select_n_q),
        .io_select_n_q(io_select_n_q), .busy_q(busy_q), .done_q(done_q), .rdata_q(rdata_q),
        .restart_addr_q(restart_addr_q), .wscr_q(wscr_q));
    ebwi_mem_model ebwi_mem_model_inst (.sys_clk(sys_clk), .addr(ext_addr_q), .wdata(ext_data_out_q),
        .rd_n(read_select_n_q), .we_n(write_enable_n_q), .access_strobe_n_n(access_strobe_n_q), .stall(stall),
        .rdata(ext_data_in), .ready(ready));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Bus cycles
    task automatic access(input logic w, input ebwi_space_t sp, input logic [15:0] a, d, input int st);
        int n, cnt, access_strobe_n, exp_n;
        stall = st[7:0];
        @(posedge sys_clk);
        #1 {req, req_write, req_space, req_addr, req_wdata} = {1'b1, w, sp, a, d};
        @(posedge sys_clk);
        #1 req = 0;
        n = 1;
        access_strobe_n = 0;
        cnt = sp == EBWI_SP_DATA ? wscr_m[8:6] : sp == EBWI_SP_IO ? wscr_m[11:9] :
              a[15] ? wscr_m[5:3] : wscr_m[2:0];
        while (done_q !== 1'b1 && n < 300) begin
            if (access_strobe_n_q === 1'b0) begin
                access_strobe_n++;
                chk("rd_n", read_select_n_q, w);
                chk("we_n", write_enable_n_q, !w);
                chk("rnw", read_not_write_q, !w);
                chk("psel_n", program_select_n_q, sp != EBWI_SP_PROG);
                chk("addr", ext_addr_q, a);
                if (w) chk("wdata", ext_data_out_q, d);
                chk("oe", ext_data_oe_q, w);
                chk("dsel_n", data_select_n_q, sp != EBWI_SP_DATA);
                chk("iosel_n", io_select_n_q, sp != EBWI_SP_IO);
                chk("busy", busy_q, 1);
            end
            @(posedge sys_clk);
            #1 n++;
        end
        chk("done", done_q, 1);
        chk("strobe_seen", access_strobe_n > 0, 1);
        chk("strobe_end", access_strobe_n_q, 1);
        // Ready crosses the pin synchroniser, so a stall only bites once the count outlasts that delay
        exp_n = (st > 0 && cnt > 3) ? st + 7 : cnt + 3;
        chk("wait_min", n >= exp_n, 1);
        chk("wait_max", n <= exp_n, 1);
        if (w) begin
            ref_mem[int'(a)] = d;
        end else begin
            chk("rdata", rdata_q, ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : a ^ 16'h5a5a);
        end
        if (st > 0) begin
            repeat (st + 1) @(posedge sys_clk); // Let the synchronised ready settle high again
            #1;
        end
    endtask
    task automatic write_wscr(input logic [15:0] v);
        @(posedge sys_clk);
        #1 {req, req_write, req_space, req_addr, req_wdata} = {1'b1, 1'b1, EBWI_SP_IO, 16'hffff, v};
        @(posedge sys_clk);
        #1 req = 0;
        repeat (5) begin
            chk("no_strobe", access_strobe_n_q, 1);
            chk("idle_busy", busy_q, 0);
            @(posedge sys_clk);
            #1;
        end
        wscr_m = v;
        chk("wscr", wscr_q, v);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] a;
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1;
        chk("wscr_rst", wscr_q, 16'h0fff);
        chk("restart", restart_addr_q, 16'h0000);
        chk("strobe_idle", access_strobe_n_q, 1);
        wscr_m = 16'h0fff;
        access(0, EBWI_SP_PROG, 16'h8000, 0, 0);
        write_wscr(16'h0038);
        access(0, EBWI_SP_PROG, 16'h7fff, 0, 0);
        access(1, EBWI_SP_PROG, 16'h8000, 16'hbeef, 0);
        access(0, EBWI_SP_PROG, 16'h8000, 0, 0);
        for (int i = 0; i < 12; i++) begin
            write_wscr(16'($random(seed)));
            for (int k = 0; k < 6; k++) begin
                a = 16'($random(seed));
                if (k < 2) a[15] = i[0];
                if (k == 5 && a == 16'hffff) a = 0;
                access(k[0], ebwi_space_t'(k / 2), a, 16'($random(seed)), (i % 4 == 3) ? 6 : 0);
            end
        end
        @(posedge sys_clk);
        #1 reset_n_pin = 0;
        repeat (5) @(posedge sys_clk);
        #1 reset_n_pin = 1;
        repeat (8) @(posedge sys_clk);
        #1 chk("pin_reset", wscr_q, 16'h0fff);
        chk("pin_restart", restart_addr_q, 16'h0000);
        chk("pin_strobe", access_strobe_n_q, 1);
        wscr_m = 16'h0fff;
        access(0, EBWI_SP_DATA, 16'h0123, 0, 0);
        complete_run();
    end
    initial begin
        #200000;
        n_fail++;
        $display("watchdog expired");
        complete_run();
    end
endmodule
`default_nettype wire
